// File: pkg/spr_defines.svh
`ifndef SPR_DEFINES_SVH
`define SPR_DEFINES_SVH
// Register indices; byte address is four times the index
`define SPR_IDX_CTRL 8'ha0
`define SPR_IDX_STAT 8'ha1
`define SPR_IDX_RATE 8'ha2
`define SPR_IDX_DATA 8'ha3
// Control field positions
`define SPR_CTRL_EN 0
`define SPR_CTRL_MST 1
`define SPR_CTRL_CPOL 2
`define SPR_CTRL_CPHA 3
// Status field positions
`define SPR_STAT_BUSY 0
`define SPR_STAT_TXE 1
`define SPR_STAT_DONE 2
// Reset values
`define SPR_RST_CTRL 4'h0
`define SPR_RST_RATE 8'h00
`define SPR_RST_DATA 8'h00
// Bus answers
`define SPR_RESP_OKAY 2'h0
`define SPR_RESP_SLVERR 2'h2
// Timing
`define SPR_CLK_MHZ 100
`define SPR_T_SEZ_MAX_NS 40
`define SPR_T_SDZ_MAX_NS 40
`define SPR_T_SLH_MIN_NS 60
`define SPR_T_SLH_MAX_NS 80
`define SPR_SEZ_CYC (`SPR_T_SEZ_MAX_NS * `SPR_CLK_MHZ / 1000)
`define SPR_SDZ_CYC (`SPR_T_SDZ_MAX_NS * `SPR_CLK_MHZ / 1000)
`define SPR_SLH_CYC ((`SPR_T_SLH_MIN_NS * `SPR_CLK_MHZ + 999) / 1000)
`endif

// File: pkg/spr_pkg.sv
package spr_pkg;
  typedef enum logic [2:0] {
    SEL_CTRL, SEL_STAT, SEL_RATE, SEL_DATA, SEL_NONE
  } spr_sel_e;

  typedef enum logic {
    M_IDLE, M_SHIFT
  } spr_mst_e;

  typedef struct packed {
    logic cpha;
    logic cpol;
    logic master;
    logic enable;
  } spr_ctrl_s;

  typedef struct packed {
    logic i;
    logic o;
    logic oe_n;
  } spr_pin_s;
endpackage : spr_pkg

// File: hdl/spr_core.sv
`timescale 1ns/1ps
`include "spr_defines.svh"
module spr_core #(
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  input wire spr_pkg::spr_pin_s sck_pin_in,
  output spr_pkg::spr_pin_s sck_pin_out,
  input wire spr_pkg::spr_pin_s mosi_pin_in,
  output spr_pkg::spr_pin_s mosi_pin_out,
  input wire spr_pkg::spr_pin_s miso_pin_in,
  output spr_pkg::spr_pin_s miso_pin_out,
  input wire logic slave_select_n
);

  localparam int SEZ_CYC = `SPR_SEZ_CYC;
  localparam int SDZ_CYC = `SPR_SDZ_CYC;
  localparam logic [3:0] SLH_LOAD = 4'(`SPR_SLH_CYC);

  function automatic spr_pkg::spr_sel_e decode(input logic [AW-1:0] a);
    logic [AW-3:0] idx;
    idx = a[AW-1:2];
    if (a[1:0] != 2'h0) return spr_pkg::SEL_NONE;
    if (idx == (AW-2)'(`SPR_IDX_CTRL)) return spr_pkg::SEL_CTRL;
    if (idx == (AW-2)'(`SPR_IDX_STAT)) return spr_pkg::SEL_STAT;
    if (idx == (AW-2)'(`SPR_IDX_RATE)) return spr_pkg::SEL_RATE;
    if (idx == (AW-2)'(`SPR_IDX_DATA)) return spr_pkg::SEL_DATA;
    return spr_pkg::SEL_NONE;
  endfunction : decode

  spr_pkg::spr_ctrl_s ctrl_q;
  logic [7:0] rate_q;
  logic [7:0] txbuf_q;
  logic txe_q;
  logic [7:0] rxbuf_q;
  logic done_q;
  spr_pkg::spr_mst_e mst_q;
  logic [7:0] half_q;
  logic [3:0] phase_q;
  logic [7:0] shift_q;
  logic mosi_q;
  logic miso_q;
  logic sck_prev_q;
  logic nss_prev_q;
  logic [2:0] sbit_q;
  logic [3:0] slh_q;

  // Bus write capture
  logic [AW-1:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_go;
  logic wr_data;
  logic wr_clr_done;
  spr_pkg::spr_sel_e wr_sel;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_sel = decode(awaddr_q);
  assign wr_data = wr_go && wstrb0_q && wr_sel == spr_pkg::SEL_DATA;
  assign wr_clr_done = wr_go && wstrb0_q && wr_sel == spr_pkg::SEL_STAT &&
                       wdata_q[`SPR_STAT_DONE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `SPR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == spr_pkg::SEL_NONE) ? `SPR_RESP_SLVERR
                                                  : `SPR_RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `SPR_RST_CTRL;
      rate_q <= `SPR_RST_RATE;
    end else if (wr_go && wstrb0_q) begin
      if (wr_sel == spr_pkg::SEL_CTRL) ctrl_q <= wdata_q[3:0];
      if (wr_sel == spr_pkg::SEL_RATE) rate_q <= wdata_q[7:0];
    end
  end

  // Bus read
  logic arready;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic busy;
  spr_pkg::spr_sel_e rd_sel;

  assign arready = !rvalid_q;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_sel = decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `SPR_RESP_OKAY;
    end else if (s_axi_arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `SPR_RESP_OKAY;
      unique case (rd_sel)
        spr_pkg::SEL_CTRL: rdata_q <= {28'h0, ctrl_q};
        spr_pkg::SEL_STAT: rdata_q <= {29'h0, done_q, txe_q, busy};
        spr_pkg::SEL_RATE: rdata_q <= {24'h0, rate_q};
        spr_pkg::SEL_DATA: rdata_q <= {24'h0, rxbuf_q};
        spr_pkg::SEL_NONE: begin
          rdata_q <= 32'h0;
          rresp_q <= `SPR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Link events
  logic mst_on;
  logic slv_on;
  logic m_start;
  logic m_half_end;
  logic m_sample;
  logic m_last;
  logic s_sel;
  logic s_fall;
  logic s_lead;
  logic s_trail;
  logic s_sample;
  logic s_shift;
  logic s_last;

  assign mst_on = ctrl_q.enable && ctrl_q.master;
  assign slv_on = ctrl_q.enable && !ctrl_q.master;
  assign m_start = mst_on && mst_q == spr_pkg::M_IDLE && !txe_q;
  assign m_half_end = mst_q == spr_pkg::M_SHIFT && half_q == rate_q;
  // Capture in the final cycle of the bit
  assign m_sample = m_half_end && phase_q[0];
  assign m_last = m_sample && phase_q == 4'hf;
  assign s_sel = slv_on && !slave_select_n;
  assign s_fall = s_sel && nss_prev_q;
  assign s_lead = s_sel && sck_prev_q == ctrl_q.cpol &&
                  sck_pin_in.i != ctrl_q.cpol;
  assign s_trail = s_sel && sck_prev_q != ctrl_q.cpol &&
                   sck_pin_in.i == ctrl_q.cpol;
  // Sample edge falls mid-bit for either phase
  assign s_sample = ctrl_q.cpha ? s_trail : s_lead;
  assign s_shift = ctrl_q.cpha ? s_lead : s_trail;
  assign s_last = s_sample && sbit_q == 3'h7;
  assign busy = mst_q == spr_pkg::M_SHIFT || s_sel;

  // Transmit buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txbuf_q <= `SPR_RST_DATA;
      txe_q <= 1'b1;
    end else if (wr_data) begin
      txbuf_q <= wdata_q[7:0];
      txe_q <= 1'b0;
    end else if (m_start || s_fall || (s_last && !s_fall)) begin
      txe_q <= 1'b1;
    end
  end

  // Master divider and sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_q <= spr_pkg::M_IDLE;
      half_q <= 8'h00;
      phase_q <= 4'h0;
    end else if (!mst_on) begin
      mst_q <= spr_pkg::M_IDLE;
      half_q <= 8'h00;
      phase_q <= 4'h0;
    end else if (m_start) begin
      mst_q <= spr_pkg::M_SHIFT;
      half_q <= 8'h00;
      phase_q <= 4'h0;
    end else if (m_half_end) begin
      // Each half lasts rate+1 cycles, never below one
      half_q <= 8'h00;
      phase_q <= 4'(phase_q + 4'h1);
      if (m_last) mst_q <= spr_pkg::M_IDLE;
    end else if (mst_q == spr_pkg::M_SHIFT) begin
      half_q <= 8'(half_q + 8'h01);
    end
  end

  // Shift register, receive buffer and data lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_q <= 8'h00;
      rxbuf_q <= `SPR_RST_DATA;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      sbit_q <= 3'h0;
      slh_q <= 4'h0;
    end else if (m_start) begin
      shift_q <= txbuf_q;
      mosi_q <= txbuf_q[7];
    end else if (m_sample) begin
      shift_q <= {shift_q[6:0], miso_pin_in.i};
      mosi_q <= shift_q[6];
      if (m_last) rxbuf_q <= {shift_q[6:0], miso_pin_in.i};
    end else if (s_fall) begin
      shift_q <= txbuf_q;
      miso_q <= txbuf_q[7];
      sbit_q <= 3'h0;
      slh_q <= 4'h0;
    end else if (s_sample) begin
      sbit_q <= 3'(sbit_q + 3'h1);
      if (s_last) begin
        rxbuf_q <= {shift_q[6:0], mosi_pin_in.i};
        shift_q <= txbuf_q;
        if (ctrl_q.cpha) slh_q <= SLH_LOAD;
      end else begin
        shift_q <= {shift_q[6:0], mosi_pin_in.i};
      end
    end else if (s_shift) begin
      miso_q <= shift_q[7];
    end else if (slh_q != 4'h0) begin
      slh_q <= 4'(slh_q - 4'h1);
      if (slh_q == 4'h1) miso_q <= shift_q[7];
    end
  end

  // Completion flag; a new completion beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (m_last || s_last) begin
      done_q <= 1'b1;
    end else if (wr_clr_done) begin
      done_q <= 1'b0;
    end
  end

  // Link edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_prev_q <= 1'b0;
      nss_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_pin_in.i;
      nss_prev_q <= slave_select_n;
    end
  end

  // Pin drive
  logic sck_act;
  assign sck_act = mst_q == spr_pkg::M_SHIFT && (phase_q[0] ^ ctrl_q.cpha);
  assign sck_pin_out.i = 1'b0;
  assign sck_pin_out.o = ctrl_q.cpol ^ sck_act;
  assign sck_pin_out.oe_n = !mst_on;
  assign mosi_pin_out.i = 1'b0;
  assign mosi_pin_out.o = mosi_q;
  assign mosi_pin_out.oe_n = !mst_on;
  assign miso_pin_out.i = 1'b0;
  assign miso_pin_out.o = miso_q;
  assign miso_pin_out.oe_n = !s_sel;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence slv_last_s;
    s_last && ctrl_q.cpha;
  endsequence

  rate_step_a: assert property (
    m_half_end && !m_last |=> half_q == 8'h00 &&
      phase_q == 4'($past(phase_q) + 4'h1))
    else $error("half period does not end at rate count");
  slave_nodiv_a: assert property (
    !mst_on |=> mst_q == spr_pkg::M_IDLE && half_q == 8'h00)
    else $error("divider runs outside master mode");
  tx_load_a: assert property (
    wr_data |=> txbuf_q == $past(wdata_q[7:0]) && !txe_q)
    else $error("data write did not load transmit buffer");
  master_start_a: assert property (
    m_start |=> mst_q == spr_pkg::M_SHIFT && mosi_q == $past(txbuf_q[7]))
    else $error("master did not start on pending byte");
  read_rx_a: assert property (
    s_axi_arvalid && arready && rd_sel == spr_pkg::SEL_DATA
      |=> rdata_q == {24'h0, $past(rxbuf_q)})
    else $error("data read not from receive buffer");
  miso_drive_a: assert property (
    slv_on && $fell(slave_select_n) |-> ##[0:SEZ_CYC] !miso_pin_out.oe_n)
    else $error("slave output not driven after select");
  miso_release_a: assert property (
    $rose(slave_select_n) |-> ##[0:SDZ_CYC] miso_pin_out.oe_n)
    else $error("slave output not released");
  slh_hold_a: assert property (
    slv_last_s |-> $stable(miso_q)[*6] ##1 slh_q == 4'h1)
    else $error("phase one output changed too early");
  idle_pol_a: assert property (
    mst_on && mst_q == spr_pkg::M_IDLE |-> sck_pin_out.o == ctrl_q.cpol)
    else $error("idle clock level wrong for polarity");
  reset_zero_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> rate_q == 8'h00 && rxbuf_q == 8'h00)
    else $error("registers not zero after reset");

endmodule : spr_core

// File: sim/spr_link_model.sv
`timescale 1ns/1ps
module spr_link_model (
  // Clock and filler pattern
  input wire logic aclk,
  input wire logic tg,
  // Link wires
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  input wire logic miso_oe_n,
  // Master role
  output logic m_sck,
  output logic m_ssn,
  output logic m_mosi,
  output logic m_mosi_en,
  // Slave role
  output logic s_miso,
  output logic s_miso_en
);
  logic pol, pha, sck_q;
  logic [7:0] sb, s_rx;
  int nl, nt, k;

  initial begin
    m_sck = 1'b0;
    m_ssn = 1'b1;
    m_mosi = 1'b0;
    m_mosi_en = 1'b0;
    s_miso_en = 1'b0;
  end

  // Slave role: arm with the byte to return
  task automatic arm(input logic [7:0] b, input logic p, input logic h);
    sb = b;
    pol = p;
    pha = h;
    nl = 0;
    nt = 0;
    s_miso_en = 1'b1;
  endtask : arm

  always @(posedge aclk) begin
    sck_q <= sck_w;
    if (s_miso_en && sck_w !== sck_q) begin
      if ((sck_w !== pol) ^ pha) s_rx <= {s_rx[6:0], mosi_w};
      if (sck_w !== pol) nl <= nl + 1;
      else nt <= nt + 1;
    end
  end

  // Outside the byte the line shows a moving pattern
  assign k = pha ? nl - 1 : nt;
  assign s_miso = (k < 0 || k > 7) ? tg : sb[7 - k];

  // Master role: one framed byte, halves of six cycles
  task automatic drive(input logic [7:0] mo, input logic p, input logic h,
      output logic [7:0] got, output int t_on, output int t_off,
      output int t_last);
    int i;
    int b;
    logic v0;
    s_miso_en = 1'b0;
    t_on = 99;
    t_off = 99;
    t_last = 99;
    got = 8'h00;
    @(posedge aclk);
    m_sck <= p;
    @(posedge aclk);
    m_ssn <= 1'b0;
    m_mosi <= mo[7];
    m_mosi_en <= 1'b1;
    for (i = 1; i < 8; i++) begin
      @(posedge aclk);
      if (miso_oe_n === 1'b0 && t_on == 99) t_on = i;
    end
    for (i = 0; i < 16; i++) begin
      @(posedge aclk);
      if (i[0] == h) got = {got[6:0], miso_w};
      m_sck <= p ^ ~i[0];
      b = h ? i / 2 : i / 2 + 1;
      if (i[0] != h && b < 8) m_mosi <= mo[7 - b];
      if (i < 15) repeat (5) @(posedge aclk);
    end
    @(posedge aclk);
    v0 = miso_w;
    for (i = 2; i < 13; i++) begin
      @(posedge aclk);
      if (miso_w !== v0 && t_last == 99) t_last = i - 1;
    end
    m_ssn <= 1'b1;
    m_mosi_en <= 1'b0;
    for (i = 1; i < 8; i++) begin
      @(posedge aclk);
      if (miso_oe_n === 1'b1 && t_off == 99) t_off = i;
    end
  endtask : drive
endmodule : spr_link_model

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "spr_defines.svh"
module testbench;
  logic aclk, aresetn, tg, slave_select_n, mst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  spr_pkg::spr_pin_s sck_pin_in, sck_pin_out, mosi_pin_in, mosi_pin_out;
  spr_pkg::spr_pin_s miso_pin_in, miso_pin_out;
  logic sck_w, mosi_w, miso_w, m_sck, m_mosi, m_mosi_en, s_miso, s_miso_en;
  logic sck_q;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] seed = 32'h10;
  logic [7:0] rate, tx, mo, got;
  int fail_count = 0;
  int n_compared = 0;
  int n_edge = 0;
  int hcnt = 0;
  int t_on, t_off, t_last;

  always #5 aclk = ~aclk;
  always @(posedge aclk) tg <= ~tg;

  // Wire levels from every party's enable
  assign sck_w = !sck_pin_out.oe_n ? sck_pin_out.o : m_sck;
  assign mosi_w = !mosi_pin_out.oe_n ? mosi_pin_out.o : m_mosi_en ? m_mosi : tg;
  assign miso_w = !miso_pin_out.oe_n ? miso_pin_out.o : s_miso_en ? s_miso : tg;
  assign sck_pin_in = '{sck_w, 1'b0, 1'b1};
  assign mosi_pin_in = '{mosi_w, 1'b0, 1'b1};
  assign miso_pin_in = '{miso_w, 1'b0, 1'b1};

  spr_core #(.AW(12)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sck_pin_in, .sck_pin_out, .mosi_pin_in, .mosi_pin_out, .miso_pin_in,
    .miso_pin_out, .slave_select_n
  );

  spr_link_model u_link (
    .aclk, .tg, .sck_w, .mosi_w, .miso_w, .miso_oe_n(miso_pin_out.oe_n),
    .m_sck, .m_ssn(slave_select_n), .m_mosi, .m_mosi_en, .s_miso, .s_miso_en
  );

  task automatic tally_and_finish;
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic give_up;
    fail_count++;
    tally_and_finish();
  endtask : give_up

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] cw(input logic ms, input logic p,
      input logic h);
    logic [31:0] c;
    c = 32'h0;
    c[`SPR_CTRL_EN] = 1'b1;
    c[`SPR_CTRL_MST] = ms;
    c[`SPR_CTRL_CPOL] = p;
    c[`SPR_CTRL_CPHA] = h;
    return c;
  endfunction : cw

  task automatic wr(input logic [7:0] x, input logic [31:0] d,
      input logic [1:0] r);
    int n;
    bq.push_back(r);
    s_axi_awaddr <= {2'h0, x, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 64) give_up();
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] x, input logic [33:0] e);
    int n;
    rq.push_back(e);
    s_axi_araddr <= {2'h0, x, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 64) give_up();
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Response watcher
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk(34'(s_axi_bresp), 34'(bq.pop_front()));
  end

  // Half period of the generated clock
  always @(posedge aclk) begin
    sck_q <= sck_w;
    if (sck_w !== sck_q) begin
      if (mst && n_edge > 0) chk(34'(hcnt), 34'(rate) + 34'h1);
      n_edge <= n_edge + 1;
      hcnt <= 1;
    end else hcnt <= hcnt + 1;
  end

  initial begin
    int m;
    int n;
    aclk = 1'b0;
    aresetn = 1'b0;
    tg = 1'b0;
    mst = 1'b0;
    rate = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SPR_IDX_RATE, 34'h0);
    rd(`SPR_IDX_DATA, 34'h0);
    rd(8'hfc, {`SPR_RESP_SLVERR, 32'h0});
    wr(8'hfc, 32'h0, `SPR_RESP_SLVERR);
    for (m = 0; m < 4; m++) begin
      rate = (m == 1) ? 8'hff : (m == 2) ? 8'h00 : 8'(rnd() & 32'h7);
      tx = 8'(rnd());
      mo = 8'(rnd());
      mst <= 1'b0;
      wr(`SPR_IDX_CTRL, cw(1'b1, m[0], m[1]), `SPR_RESP_OKAY);
      wr(`SPR_IDX_RATE, {24'(rnd() >> 8), rate}, `SPR_RESP_OKAY);
      rd(`SPR_IDX_CTRL, 34'(cw(1'b1, m[0], m[1])));
      rd(`SPR_IDX_RATE, {26'h0, rate});
      chk(34'(sck_w), 34'(m[0]));
      u_link.arm(mo, m[0], m[1]);
      n_edge <= 0;
      mst <= 1'b1;
      wr(`SPR_IDX_DATA, {24'h0, tx}, `SPR_RESP_OKAY);
      for (n = 0; n < 5000 && n_edge < 16; n++) @(posedge aclk);
      if (n == 5000) give_up();
      repeat (int'(rate) + 8) @(posedge aclk);
      chk(34'(n_edge), 34'd16);
      chk(34'(sck_w), 34'(m[0]));
      chk(34'(u_link.s_rx), 34'(tx));
      rd(`SPR_IDX_DATA, {26'h0, mo});
      // Idle, buffer empty, transfer done; then clear done
      rd(`SPR_IDX_STAT, 34'h6);
      wr(`SPR_IDX_STAT, 32'h4, `SPR_RESP_OKAY);
      rd(`SPR_IDX_STAT, 34'h2);
    end
    for (m = 0; m < 2; m++) begin
      mst <= 1'b0;
      tx = m[0] ? 8'h35 : 8'(rnd());
      mo = 8'(rnd());
      wr(`SPR_IDX_CTRL, cw(1'b0, ~m[0], m[0]), `SPR_RESP_OKAY);
      chk(34'(sck_pin_out.oe_n), 34'h1);
      wr(`SPR_IDX_DATA, {24'h0, tx}, `SPR_RESP_OKAY);
      u_link.drive(mo, ~m[0], m[0], got, t_on, t_off, t_last);
      chk(34'(got), 34'(tx));
      chk(34'(t_on <= 4), 34'h1);
      chk(34'(t_off <= 4), 34'h1);
      if (m == 1) chk(34'(t_last >= 6 && t_last <= 8), 34'h1);
      rd(`SPR_IDX_DATA, {26'h0, mo});
    end
    tally_and_finish();
  end
endmodule : testbench
